// File: rsd_params.svh
`ifndef RSD_PARAMS_SVH
`define RSD_PARAMS_SVH

// register width and selector width of the load port
`define RSD_W 16
`define RSD_SEL_W 5

// reset contents
`define RSD_FLAGS_RST 16'hF002
`define RSD_IP_RST 16'h0000
`define RSD_CS_RST 16'hFFFF
`define RSD_SEG_RST 16'h0000
`define RSD_RELOC_RST 16'h20FF
`define RSD_PART_RST 16'h0000
`define RSD_REFR_RST 16'h0000
`define RSD_UMS_RST 16'hF03B
`define RSD_SCTL_RST 16'h0000
`define RSD_SDIV_RST 16'h0000
`define RSD_SIRQ_RST 16'h001F
`define RSD_EIRQ_RST 16'h000F
`define RSD_INSRV_RST 16'h0000
`define RSD_PRIM_RST 16'h0007
`define RSD_INTERRUPT_MASK_RST 16'h07FD
`define RSD_BOOT_ADDR 20'hF_FFF0

// release level: revision in the upper byte
`define RSD_REV_LSB 8
`define RSD_REV_W 8
`define RSD_LOW_UNDEF 8'h00

// load port selectors
`define RSD_SEL_FLAGS 5'h00
`define RSD_SEL_IP 5'h01
`define RSD_SEL_CS 5'h02
`define RSD_SEL_DS 5'h03
`define RSD_SEL_ES 5'h04
`define RSD_SEL_SS 5'h05
`define RSD_SEL_RELOC 5'h07
`define RSD_SEL_PART 5'h08
`define RSD_SEL_REFR 5'h09
`define RSD_SEL_UMS 5'h0A
`define RSD_SEL_LMS 5'h0B
`define RSD_SEL_SCTL0 5'h0C
`define RSD_SEL_SDIV0 5'h0E
`define RSD_SEL_SIRQ0 5'h10
`define RSD_SEL_EIRQ0 5'h12
`define RSD_SEL_DIRQ0 5'h17
`define RSD_SEL_TIRQ 5'h19
`define RSD_SEL_INSRV 5'h1A
`define RSD_SEL_PRIM 5'h1B
`define RSD_SEL_INTERRUPT_MASK 5'h1C

// start-up interval after reset release
`define RSD_CLK_NS 100
`define RSD_STARTUP_NS 700
`define RSD_STARTUP_CYC ((`RSD_STARTUP_NS + `RSD_CLK_NS - 1) / `RSD_CLK_NS)
`define RSD_CNT_W 8

`endif

// File: rsd_pkg.sv
package rsd_pkg;

  typedef enum logic [2:0] {
    RSD_ST_RESET = 3'b001,
    RSD_ST_WAIT = 3'b010,
    RSD_ST_RUN = 3'b100
  } rsd_state_t;

  typedef struct packed {
    rsd_state_t st;
    logic [7:0] cnt;
    logic start;
    logic halted;
    logic [19:0] fetch;
    logic [15:0] flags;
    logic [15:0] ip;
    logic [15:0] cs;
    logic [15:0] ds;
    logic [15:0] es;
    logic [15:0] ss;
    logic [15:0] rel;
    logic [15:0] reloc;
    logic [15:0] part;
    logic [15:0] refr;
    logic [15:0] ums;
    logic [15:0] lms;
    logic lms_ok;
    logic [1:0][15:0] sctl;
    logic [1:0][15:0] sdiv;
    logic [1:0][15:0] sirq;
    logic [4:0][15:0] eirq;
    logic [1:0][15:0] dirq;
    logic [15:0] tirq;
    logic [15:0] insrv;
    logic [15:0] prim;
    logic [15:0] interrupt_mask;
  } rsd_regs_t;

endpackage : rsd_pkg

// File: rsd_reset_bank.sv
`timescale 1ns/1ps
`include "rsd_params.svh"

module rsd_reset_bank #(
  parameter int STARTUP_CYCLES = `RSD_STARTUP_CYC,
  parameter logic [7:0] REVISION = 8'h5A // arbitrary value
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // software load port
  input wire logic wr_en_in,
  input wire logic [`RSD_SEL_W-1:0] wr_sel_in,
  input wire logic [`RSD_W-1:0] wr_data_in,
  // sequencing
  output logic halted_out,
  output logic fetch_start_out,
  output logic [19:0] fetch_addr_out,
  // processor registers
  output logic [`RSD_W-1:0] flags_out,
  output logic [`RSD_W-1:0] instruction_pointer_out,
  output logic [`RSD_W-1:0] code_segment_out,
  output logic [`RSD_W-1:0] data_segment_out,
  output logic [`RSD_W-1:0] extra_segment_out,
  output logic [`RSD_W-1:0] stack_segment_out,
  output logic [`RSD_W-1:0] release_level_out,
  // configuration, memory and refresh
  output logic [`RSD_W-1:0] control_block_relocation_out,
  output logic [`RSD_W-1:0] memory_partition_out,
  output logic [`RSD_W-1:0] refresh_enable_out,
  output logic [`RSD_W-1:0] upper_memory_select_reg_out,
  output logic [`RSD_W-1:0] lower_memory_select_reg_out,
  output logic lower_memory_select_valid_out,
  // serial ports
  output logic [1:0][`RSD_W-1:0] serial_control_out,
  output logic [1:0][`RSD_W-1:0] serial_divisor_out,
  output logic [1:0][`RSD_W-1:0] serial_irq_control_out,
  // interrupt controller
  output logic [4:0][`RSD_W-1:0] ext_irq_control_out,
  output logic [1:0][`RSD_W-1:0] dma_irq_control_out,
  output logic [`RSD_W-1:0] timer_irq_control_out,
  output logic [`RSD_W-1:0] in_service_out,
  output logic [`RSD_W-1:0] priority_mask_out,
  output logic [`RSD_W-1:0] interrupt_mask_out
);
  import rsd_pkg::*;

  initial
  begin
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 255)
    begin
      $error("STARTUP_CYCLES out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  rsd_regs_t s_q;
  rsd_regs_t s_d;

  localparam logic [7:0] START_LAST = 8'(STARTUP_CYCLES - 1);

  always_comb
  begin
    s_d = s_q;
    if (sys_rst_in)
    begin
      // reset wins over the clock enable so a frozen part still initialises
      s_d.st = RSD_ST_RESET;
      s_d.start = 1'b0;
      s_d.cnt = 8'h00;
      s_d.fetch = `RSD_BOOT_ADDR;
      s_d.flags = `RSD_FLAGS_RST;
      s_d.ip = `RSD_IP_RST;
      s_d.cs = `RSD_CS_RST;
      s_d.ds = `RSD_SEG_RST;
      s_d.es = `RSD_SEG_RST;
      s_d.ss = `RSD_SEG_RST;
      s_d.rel = {REVISION, `RSD_LOW_UNDEF};
      s_d.reloc = `RSD_RELOC_RST;
      s_d.part = `RSD_PART_RST;
      s_d.refr = `RSD_REFR_RST;
      s_d.ums = `RSD_UMS_RST;
      // contents left as they were, only the valid flag drops
      s_d.lms_ok = 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        s_d.sctl[i] = `RSD_SCTL_RST;
        s_d.sdiv[i] = `RSD_SDIV_RST;
        s_d.sirq[i] = `RSD_SIRQ_RST;
        s_d.dirq[i] = `RSD_EIRQ_RST;
      end
      for (int i = 0; i < 5; i++)
      begin
        s_d.eirq[i] = `RSD_EIRQ_RST;
      end
      s_d.tirq = `RSD_EIRQ_RST;
      s_d.insrv = `RSD_INSRV_RST;
      s_d.prim = `RSD_PRIM_RST;
      s_d.interrupt_mask = `RSD_INTERRUPT_MASK_RST;
    end
    else if (clk_en_in)
    begin
      // the pulse is state too, so a frozen part holds it
      s_d.start = 1'b0;
      unique case (s_q.st)
        RSD_ST_RESET:
        begin
          s_d.st = RSD_ST_WAIT;
          s_d.cnt = 8'h00;
        end
        RSD_ST_WAIT:
        begin
          if (s_q.cnt == START_LAST)
          begin
            s_d.st = RSD_ST_RUN;
            s_d.start = 1'b1;
            s_d.fetch = 20'({s_q.cs, 4'h0}) + 20'(s_q.ip);
          end
          else
          begin
            s_d.cnt = s_q.cnt + 8'h01;
          end
        end
        RSD_ST_RUN:
        begin
          s_d.st = RSD_ST_RUN;
        end
      endcase
      // loads only once running; release level is read only
      if (wr_en_in && s_q.st == RSD_ST_RUN)
      begin
        unique case (wr_sel_in)
          `RSD_SEL_FLAGS: s_d.flags = wr_data_in;
          `RSD_SEL_IP: s_d.ip = wr_data_in;
          `RSD_SEL_CS: s_d.cs = wr_data_in;
          `RSD_SEL_DS: s_d.ds = wr_data_in;
          `RSD_SEL_ES: s_d.es = wr_data_in;
          `RSD_SEL_SS: s_d.ss = wr_data_in;
          `RSD_SEL_RELOC: s_d.reloc = wr_data_in;
          `RSD_SEL_PART: s_d.part = wr_data_in;
          `RSD_SEL_REFR: s_d.refr = wr_data_in;
          `RSD_SEL_UMS: s_d.ums = wr_data_in;
          `RSD_SEL_LMS:
          begin
            s_d.lms = wr_data_in;
            s_d.lms_ok = 1'b1;
          end
          `RSD_SEL_SCTL0: s_d.sctl[0] = wr_data_in;
          `RSD_SEL_SCTL0 + 5'h01: s_d.sctl[1] = wr_data_in;
          `RSD_SEL_SDIV0: s_d.sdiv[0] = wr_data_in;
          `RSD_SEL_SDIV0 + 5'h01: s_d.sdiv[1] = wr_data_in;
          `RSD_SEL_SIRQ0: s_d.sirq[0] = wr_data_in;
          `RSD_SEL_SIRQ0 + 5'h01: s_d.sirq[1] = wr_data_in;
          `RSD_SEL_EIRQ0: s_d.eirq[0] = wr_data_in;
          `RSD_SEL_EIRQ0 + 5'h01: s_d.eirq[1] = wr_data_in;
          `RSD_SEL_EIRQ0 + 5'h02: s_d.eirq[2] = wr_data_in;
          `RSD_SEL_EIRQ0 + 5'h03: s_d.eirq[3] = wr_data_in;
          `RSD_SEL_EIRQ0 + 5'h04: s_d.eirq[4] = wr_data_in;
          `RSD_SEL_DIRQ0: s_d.dirq[0] = wr_data_in;
          `RSD_SEL_DIRQ0 + 5'h01: s_d.dirq[1] = wr_data_in;
          `RSD_SEL_TIRQ: s_d.tirq = wr_data_in;
          `RSD_SEL_INSRV: s_d.insrv = wr_data_in;
          `RSD_SEL_PRIM: s_d.prim = wr_data_in;
          `RSD_SEL_INTERRUPT_MASK: s_d.interrupt_mask = wr_data_in;
          default: s_d.st = s_q.st;
        endcase
      end
    end
    // registered copy of the state decode keeps the halt output glitch free
    s_d.halted = (s_d.st != RSD_ST_RUN);
  end

  // lms is deliberately outside reset, so it stays unknown until loaded
  always_ff @(posedge clk_in)
  begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign halted_out = s_q.halted;

  assign fetch_start_out = s_q.start;
  assign fetch_addr_out = s_q.fetch;
  assign flags_out = s_q.flags;
  assign instruction_pointer_out = s_q.ip;
  assign code_segment_out = s_q.cs;
  assign data_segment_out = s_q.ds;
  assign extra_segment_out = s_q.es;
  assign stack_segment_out = s_q.ss;
  assign release_level_out = s_q.rel;
  assign control_block_relocation_out = s_q.reloc;
  assign memory_partition_out = s_q.part;
  assign refresh_enable_out = s_q.refr;
  assign upper_memory_select_reg_out = s_q.ums;
  assign lower_memory_select_reg_out = s_q.lms;
  assign lower_memory_select_valid_out = s_q.lms_ok;
  assign serial_control_out = s_q.sctl;
  assign serial_divisor_out = s_q.sdiv;
  assign serial_irq_control_out = s_q.sirq;
  assign ext_irq_control_out = s_q.eirq;
  assign dma_irq_control_out = s_q.dirq;
  assign timer_irq_control_out = s_q.tirq;
  assign in_service_out = s_q.insrv;
  assign priority_mask_out = s_q.prim;
  assign interrupt_mask_out = s_q.interrupt_mask;

  ////////////////////////////////////////////////////////////////////////////
  // check helper: enabled edges since release, counted apart from the state machine
  // so an off-by-one in the wait counter shows up instead of being copied
  logic [8:0] boot_edges_q;
  logic boot_seen_q;
  localparam logic [8:0] BOOT_EDGE = 9'(STARTUP_CYCLES + 1);

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      boot_edges_q <= 9'h000;
      boot_seen_q <= 1'b0;
    end
    else
    begin
      if (clk_en_in && !boot_seen_q)
      begin
        boot_edges_q <= boot_edges_q + 9'h001;
      end
      if (fetch_start_out)
      begin
        boot_seen_q <= 1'b1;
      end
    end
  end

  // checks sample the first edge after release, when reset is already low
  a_boot_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> code_segment_out == 16'hFFFF && instruction_pointer_out == 16'h0000)
    else $error("boot segment or pointer wrong after reset");
  a_segments_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> (data_segment_out | extra_segment_out | stack_segment_out) == 16'h0000)
    else $error("segments not cleared");
  a_flags_reset: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> flags_out == 16'hF002)
    else $error("flags reset value wrong");
  a_release_rev: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> release_level_out[15:8] == REVISION)
    else $error("revision byte wrong");
  a_reloc_reset: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> control_block_relocation_out == 16'h20FF)
    else $error("relocation reset value wrong");
  a_mem_refresh: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> memory_partition_out == 16'h0000 && refresh_enable_out == 16'h0000)
    else $error("partition or refresh not cleared");
  a_upper_select: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> upper_memory_select_reg_out == 16'hF03B)
    else $error("upper select reset value wrong");
  a_lower_invalid: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> !lower_memory_select_valid_out)
    else $error("lower select flagged valid after reset");
  a_serial_reset: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> serial_control_out == '0 && serial_divisor_out == '0
      && serial_irq_control_out == {16'h001F, 16'h001F})
    else $error("serial reset values wrong");
  a_irq_sources: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> ext_irq_control_out == {5{16'h000F}}
      && dma_irq_control_out == {2{16'h000F}} && timer_irq_control_out == 16'h000F)
    else $error("interrupt source controls wrong");
  a_irq_masks: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> in_service_out == 16'h0000 && priority_mask_out == 16'h0007
      && interrupt_mask_out == 16'h07FD)
    else $error("interrupt mask state wrong");

  // sequencing around reset and start-up
  a_halt_in_reset: assert property (@(posedge clk_in)
    sys_rst_in |=> halted_out && !fetch_start_out)
    else $error("activity during reset");
  a_boot_start: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !boot_seen_q |-> fetch_start_out == (boot_edges_q == BOOT_EDGE))
    else $error("start-up fetch missing or misplaced");
  a_boot_address: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    fetch_start_out |-> fetch_addr_out == 20'hF_FFF0)
    else $error("start-up fetch address wrong");
  a_start_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    fetch_start_out && clk_en_in |=> !fetch_start_out)
    else $error("start pulse longer than one enabled cycle");
  a_no_load_halted: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    halted_out && wr_en_in |=> $stable(code_segment_out) && $stable(flags_out)
      && !lower_memory_select_valid_out)
    else $error("load taken while halted");
  a_release_ro: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in |=> $stable(release_level_out))
    else $error("release level changed outside reset");
  a_frozen_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !clk_en_in |=> $stable(halted_out) && $stable(fetch_start_out)
      && $stable(code_segment_out) && $stable(interrupt_mask_out))
    else $error("state moved while clock enable low");
  a_lower_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && !halted_out && wr_en_in && wr_sel_in == `RSD_SEL_LMS
      |=> lower_memory_select_valid_out && lower_memory_select_reg_out == $past(wr_data_in))
    else $error("lower select load lost");

  // one load check per entry, so a swapped index shows up
  for (genvar g = 0; g < 5; g++)
  begin : g_ext_load
    a_ext_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in && !halted_out && wr_en_in && wr_sel_in == 5'(`RSD_SEL_EIRQ0 + g)
        |=> ext_irq_control_out[g] == $past(wr_data_in))
      else $error("external interrupt control load lost");
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_serial_load
    a_serial_ctl_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in && !halted_out && wr_en_in && wr_sel_in == 5'(`RSD_SEL_SCTL0 + g)
        |=> serial_control_out[g] == $past(wr_data_in))
      else $error("serial control load lost");
    a_serial_div_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clk_en_in && !halted_out && wr_en_in && wr_sel_in == 5'(`RSD_SEL_SDIV0 + g)
        |=> serial_divisor_out[g] == $past(wr_data_in))
      else $error("serial divisor load lost");
  end

  c_reset_release: cover property (@(posedge clk_in) $fell(sys_rst_in));
  c_boot_fetch: cover property (@(posedge clk_in) fetch_start_out);
  c_lower_loaded: cover property (@(posedge clk_in) $rose(lower_memory_select_valid_out));
  c_frozen_wait: cover property (@(posedge clk_in) halted_out && !sys_rst_in && !clk_en_in);
  c_refused_load: cover property (@(posedge clk_in) halted_out && wr_en_in && !sys_rst_in);

endmodule : rsd_reset_bank

// File: tb_reset_state_defaults.sv
`timescale 1ns/1ps
`include "rsd_params.svh"

module tb_reset_state_defaults;
  import rsd_pkg::*;
  // short start-up wait keeps the run brief
  localparam int STARTUP = 2;
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  typedef struct packed {logic [5:0] idx; logic [15:0] exp; logic [15:0] mask;} rsd_note_t;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic wr_en_in = 1'b0;
  logic [`RSD_SEL_W-1:0] wr_sel_in = 5'h00;
  logic [`RSD_W-1:0] wr_data_in = 16'h0000;
  logic halted_out, fetch_start_out, lower_memory_select_valid_out;
  logic [19:0] fetch_addr_out;
  logic [`RSD_W-1:0] flags_out, instruction_pointer_out, code_segment_out, data_segment_out, extra_segment_out;
  logic [`RSD_W-1:0] stack_segment_out, release_level_out, control_block_relocation_out, memory_partition_out;
  logic [`RSD_W-1:0] refresh_enable_out, upper_memory_select_reg_out, lower_memory_select_reg_out;
  logic [`RSD_W-1:0] timer_irq_control_out, in_service_out, priority_mask_out, interrupt_mask_out;
  logic [1:0][`RSD_W-1:0] serial_control_out, serial_divisor_out, serial_irq_control_out, dma_irq_control_out;
  logic [4:0][`RSD_W-1:0] ext_irq_control_out;
  logic [34:0][15:0] view;
  logic [15:0] model [0:31];
  logic lms_ok = 1'b0;
  logic [31:0] seed = 32'h9b62_d388;
  rsd_note_t notes [$];
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  rsd_reset_bank #(.STARTUP_CYCLES(STARTUP), .REVISION(REV)) dut (
    .clk_in, .sys_rst_in, .clk_en_in, .wr_en_in, .wr_sel_in, .wr_data_in, .halted_out, .fetch_start_out,
    .fetch_addr_out, .flags_out, .instruction_pointer_out, .code_segment_out, .data_segment_out,
    .extra_segment_out, .stack_segment_out, .release_level_out, .control_block_relocation_out,
    .memory_partition_out, .refresh_enable_out, .upper_memory_select_reg_out, .lower_memory_select_reg_out,
    .lower_memory_select_valid_out, .serial_control_out, .serial_divisor_out, .serial_irq_control_out,
    .ext_irq_control_out, .dma_irq_control_out, .timer_irq_control_out, .in_service_out, .priority_mask_out,
    .interrupt_mask_out);

  // outputs laid out by load selector; 20h valid, 21h halted, 22h start pulse
  assign view = {{15'h0000, fetch_start_out}, {15'h0000, halted_out}, {15'h0000, lower_memory_select_valid_out},
    48'h0000_0000_0000, interrupt_mask_out, priority_mask_out, in_service_out, timer_irq_control_out,
    dma_irq_control_out, ext_irq_control_out, serial_irq_control_out, serial_divisor_out, serial_control_out,
    lower_memory_select_reg_out, upper_memory_select_reg_out, refresh_enable_out, memory_partition_out,
    control_block_relocation_out, release_level_out, stack_segment_out, extra_segment_out, data_segment_out,
    code_segment_out, instruction_pointer_out, flags_out};

  always #50 clk_in = ~clk_in;

////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [15:0] rst_val(input logic [4:0] s);
    case (s)
      5'h00: return 16'hf002;
      5'h02: return 16'hffff;
      5'h06: return {REV, 8'h00};
      5'h07: return 16'h20ff;
      5'h0a: return 16'hf03b;
      5'h10, 5'h11: return 16'h001f;
      5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19: return 16'h000f;
      5'h1b: return 16'h0007;
      5'h1c: return 16'h07fd;
      default: return 16'h0000;
    endcase
  endfunction : rst_val

  // low byte of release level and an unwritten lower select are never compared
  task automatic note(input logic [5:0] idx, input logic [15:0] exp);
    notes.push_back('{idx, exp, idx == 6'h06 ? 16'hff00 : (idx == 6'h0b && !lms_ok) ? 16'h0000 : 16'hffff});
  endtask : note

  task automatic compare(input string what, input logic [19:0] exp, input logic [19:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : compare

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

////////////////////////////////////////////////////////////////////////////////
  // notes pushed at a rising edge are settled by the falling edge
  always @(negedge clk_in)
  begin : watch_regs
    rsd_note_t n;
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      compare($sformatf("view %0h", n.idx), {4'h0, n.exp & n.mask}, {4'h0, view[n.idx] & n.mask});
    end
  end

  always @(posedge clk_in)
  begin
    #1;
    cycles++;
    if (fetch_start_out === 1'b1)
      compare("boot fetch address", 20'hf_fff0, fetch_addr_out);
    if (cycles == 1000)
    begin
      fails++;
      test_done();
    end
  end

////////////////////////////////////////////////////////////////////////////////
  task automatic check_all();
    for (int s = 0; s < 32; s++)
      note(6'(s), model[s]);
    note(6'h20, {15'h0000, lms_ok});
  endtask : check_all

  // code segment loads are held up through reset and wait; all must be refused
  task automatic do_reset(input logic en);
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    clk_en_in <= en;
    wr_en_in <= 1'b1;
    wr_sel_in <= 5'h02;
    wr_data_in <= 16'(rnd());
    repeat (4) @(posedge clk_in);
    note(6'h21, 16'h0001);
    sys_rst_in <= 1'b0;
    clk_en_in <= 1'b1;
    for (int n = 1; n <= STARTUP + 2; n++)
    begin
      @(posedge clk_in);
      wr_en_in <= (n < STARTUP + 1);
      note(6'h21, {15'h0000, n <= STARTUP});
      note(6'h22, {15'h0000, n == STARTUP + 1});
    end
    lms_ok = 1'b0;
    for (int s = 0; s < 32; s++)
      if (s != 11)
        model[s] = rst_val(5'(s));
    check_all();
  endtask : do_reset

  // back-to-back loads; each is checked on the falling edge after the edge that takes it
  task automatic load_all(input logic en, input logic shuffle, input int count);
    logic [4:0] sel;
    logic [15:0] data;
    for (int i = 0; i <= count; i++)
    begin
      @(posedge clk_in);
      if (i > 0)
      begin
        if (en && sel != 5'h06 && sel <= 5'h1c)
          model[sel] = data;
        if (en && sel == 5'h0b)
          lms_ok = 1'b1;
        note({1'b0, sel}, model[sel]);
      end
      sel = shuffle ? 5'(rnd()) : 5'(i);
      data = 16'(rnd());
      wr_en_in <= (i < count);
      wr_sel_in <= sel;
      wr_data_in <= data;
      clk_en_in <= (i < count) ? en : 1'b1;
    end
    note(6'h20, {15'h0000, lms_ok});
  endtask : load_all

////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset(1'b1);
    $display("test reset defaults done");
    load_all(1'b0, 1'b0, 32);
    $display("test frozen loads done");
    load_all(1'b1, 1'b0, 32);
    $display("test ordered loads done");
    load_all(1'b1, 1'b1, 64);
    check_all();
    $display("test random loads done");
    do_reset(1'b0);
    $display("test mid-run reset done");
    load_all(1'b1, 1'b1, 32);
    check_all();
    $display("test reload done");
    @(posedge clk_in);
    test_done();
  end

endmodule : tb_reset_state_defaults
